/* rtl/bdfe_defines.svh */
// timing counts, field positions and reset values of the bus-driver flag and error logic
`ifndef BDFE_DEFINES_SVH
`define BDFE_DEFINES_SVH

`define BDFE_CLK_PERIOD_NS 10
`define BDFE_CNT_W 18

// longest transmit-active time, in microseconds (1.5 ms)
`define BDFE_TX_ACTIVE_MAX_US 1500
`define BDFE_TX_ACTIVE_MAX_CYC ((`BDFE_TX_ACTIVE_MAX_US * 1000) / `BDFE_CLK_PERIOD_NS)
// filter and hold times, in microseconds
`define BDFE_CORE_UV_DETECT_US 10
`define BDFE_CORE_UV_DETECT_CYC ((`BDFE_CORE_UV_DETECT_US * 1000) / `BDFE_CLK_PERIOD_NS)
`define BDFE_CORE_UV_RECOVERY_US 20
`define BDFE_CORE_UV_RECOVERY_CYC ((`BDFE_CORE_UV_RECOVERY_US * 1000) / `BDFE_CLK_PERIOD_NS)
`define BDFE_IO_UV_DETECT_US 10
`define BDFE_IO_UV_DETECT_CYC ((`BDFE_IO_UV_DETECT_US * 1000) / `BDFE_CLK_PERIOD_NS)
`define BDFE_IO_UV_RECOVERY_US 20
`define BDFE_IO_UV_RECOVERY_CYC ((`BDFE_IO_UV_RECOVERY_US * 1000) / `BDFE_CLK_PERIOD_NS)
`define BDFE_MODE_SELECT_US 20
`define BDFE_MODE_SELECT_CYC ((`BDFE_MODE_SELECT_US * 1000) / `BDFE_CLK_PERIOD_NS)
`define BDFE_MIN_FAULT_IND_US 50
`define BDFE_MIN_FAULT_IND_CYC ((`BDFE_MIN_FAULT_IND_US * 1000) / `BDFE_CLK_PERIOD_NS)
// delay from a transmit-data edge to the bus sample, in nanoseconds
`define BDFE_BUS_SAMPLE_NS 40
`define BDFE_BUS_SAMPLE_CYC ((`BDFE_BUS_SAMPLE_NS + `BDFE_CLK_PERIOD_NS - 1) / `BDFE_CLK_PERIOD_NS)

// serial frame length in clock falling edges
`define BDFE_SPI_FRAME_EDGES 6'h10

// positions in the synchronised input vector
`define BDFE_IN_W 11
`define BDFE_IN_TXD 0
`define BDFE_IN_TEN_N 1
`define BDFE_IN_GUARD 2
`define BDFE_IN_STBY_N 3
`define BDFE_IN_CS_N 4
`define BDFE_IN_SCK 5
`define BDFE_IN_BUS_RX 6
`define BDFE_IN_WAKE 7
`define BDFE_IN_OTEMP 8
`define BDFE_IN_CORE_UV 9
`define BDFE_IN_IO_UV 10
// pulled-up inputs and the recessive bus read high at reset
`define BDFE_IN_RST 11'h072

// positions of the latched status bits s4 to s10
`define BDFE_ST_W 7
`define BDFE_ST_PWR_ON 0
`define BDFE_ST_BUS_ERR 1
`define BDFE_ST_THERMAL 2
`define BDFE_ST_TIMEOUT 3
`define BDFE_ST_CORE_UV 4
`define BDFE_ST_IO_UV 5
`define BDFE_ST_SPI_ERR 6

`endif

/* rtl/bdfe_pkg.sv */
// types of the bus-driver flag and error logic
package bdfe_pkg;
   // error-signalling mode, one-hot
   typedef enum logic [1:0] {
      BDFE_ESIG_LATCHED = 2'h1,
      BDFE_ESIG_TRACK = 2'h2
   } bdfe_esig_type;
endpackage

/* rtl/bdfe_filter.sv */
// level filter: flag follows a level after it has held for a set or clear time; clear_now drops it at once
`timescale 1ns/100ps
module bdfe_filter #(
   parameter int unsigned SET_CYC = 1,
   parameter int unsigned CLR_CYC = 1,
   parameter int unsigned CNT_W = 18
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic level,
   input wire logic clear_now,
   output logic flag
);
   logic [CNT_W-1:0] cnt;

   // count while level and flag disagree; an early clear overrides the filter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         flag <= 1'b0;
      end else if (clear_now) begin
         cnt <= '0;
         flag <= 1'b0;
      end else if (level == flag) begin
         cnt <= '0;
      end else if (!flag && cnt == CNT_W'(SET_CYC - 1)) begin
         cnt <= '0;
         flag <= 1'b1;
      end else if (flag && cnt == CNT_W'(CLR_CYC - 1)) begin
         cnt <= '0;
         flag <= 1'b0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule // bdfe_filter

/* rtl/bdfe_top.sv */
// internal flags, transmitter-ready, common error flag and fault pin of the bus driver
`timescale 1ns/100ps
`include "bdfe_defines.svh"
module bdfe_top
   import bdfe_pkg::*;
#(
   parameter int unsigned TX_ACTIVE_MAX_CYC = `BDFE_TX_ACTIVE_MAX_CYC,
   parameter int unsigned CORE_UV_DETECT_CYC = `BDFE_CORE_UV_DETECT_CYC,
   parameter int unsigned CORE_UV_RECOVERY_CYC = `BDFE_CORE_UV_RECOVERY_CYC,
   parameter int unsigned IO_UV_DETECT_CYC = `BDFE_IO_UV_DETECT_CYC,
   parameter int unsigned IO_UV_RECOVERY_CYC = `BDFE_IO_UV_RECOVERY_CYC,
   parameter int unsigned MODE_SELECT_CYC = `BDFE_MODE_SELECT_CYC,
   parameter int unsigned MIN_FAULT_IND_CYC = `BDFE_MIN_FAULT_IND_CYC,
   parameter int unsigned BUS_SAMPLE_CYC = `BDFE_BUS_SAMPLE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tx_data_in,
   input wire logic transmit_enable_n,
   input wire logic guardian_enable,
   input wire logic standby_n,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic bus_rx_level,
   input wire logic bus_wakeup,
   input wire logic over_temp,
   input wire logic core_below_uv,
   input wire logic io_below_uv,
   output logic receive_data_out,
   output logic fault_indicator_n,
   output logic tx_drive_enable,
   output logic tx_ready,
   output logic normal_mode,
   output logic wake_flag,
   output logic power_on_flag,
   output logic bus_err_flag,
   output logic thermal_flag,
   output logic timeout_flag,
   output logic core_uv_flag,
   output logic io_uv_flag,
   output logic spi_err_flag,
   output logic error_flag,
   output logic [`BDFE_ST_W-1:0] status_bits,
   output logic track_mode,
   output logic cs_pull_down
);
   localparam int unsigned CW = `BDFE_CNT_W;
   logic [`BDFE_IN_W-1:0] in_raw;
   logic [`BDFE_IN_W-1:0] in_meta;
   logic [`BDFE_IN_W-1:0] in_s;
   logic [`BDFE_IN_W-1:0] in_d;
   logic next_normal;
   logic normal_entry;
   logic tx_on;
   logic mode_req;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;
   logic frame_bad;
   logic readout_ok;
   logic any_err;
   logic ind_req;
   logic next_wake_rise;
   logic [5:0] edge_cnt;
   logic [3:0] samp_cnt;
   logic [CW-1:0] tx_active_cnt;
   logic [CW-1:0] hold_cnt;
   logic [`BDFE_ST_W-1:0] flag_vec;
   bdfe_esig_type esig;

   // two-stage synchroniser for every pin and comparator output; in_s is read, and its delayed copy in_d for edge detection
   assign in_raw = {io_below_uv, core_below_uv, over_temp, bus_wakeup, bus_rx_level, spi_sck, spi_cs_n,
                    standby_n, guardian_enable, transmit_enable_n, tx_data_in};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_meta <= `BDFE_IN_RST;
         in_s <= `BDFE_IN_RST;
         in_d <= `BDFE_IN_RST;
      end else begin
         in_meta <= in_raw;
         in_s <= in_meta;
         in_d <= in_s;
      end
   end

   // supply filters; the I/O one is also cut short by a new wakeup
   bdfe_filter #(.SET_CYC(CORE_UV_DETECT_CYC), .CLR_CYC(CORE_UV_RECOVERY_CYC), .CNT_W(CW)) u_core_uv (
      .clk(clk),
      .rstn(rstn),
      .level(in_s[`BDFE_IN_CORE_UV]),
      .clear_now(1'b0),
      .flag(core_uv_flag)
   );
   bdfe_filter #(.SET_CYC(IO_UV_DETECT_CYC), .CLR_CYC(IO_UV_RECOVERY_CYC), .CNT_W(CW)) u_io_uv (
      .clk(clk),
      .rstn(rstn),
      .level(in_s[`BDFE_IN_IO_UV]),
      .clear_now(next_wake_rise),
      .flag(io_uv_flag)
   );

   // mode selection request: chip select low, clock high, I/O supply good
   assign mode_req = !in_s[`BDFE_IN_CS_N] && in_s[`BDFE_IN_SCK] && !io_uv_flag;
   logic mode_held;
   bdfe_filter #(.SET_CYC(MODE_SELECT_CYC), .CLR_CYC(1), .CNT_W(CW)) u_mode_sel (
      .clk(clk),
      .rstn(rstn),
      .level(mode_req),
      .clear_now(1'b0),
      .flag(mode_held)
   );

   // error-signalling mode; track mode is kept until the next power-up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         esig <= BDFE_ESIG_LATCHED;
      end else begin
         case (esig)
            BDFE_ESIG_LATCHED: begin
               if (mode_held) begin
                  esig <= BDFE_ESIG_TRACK;
               end
            end
            BDFE_ESIG_TRACK: esig <= BDFE_ESIG_TRACK;
            default: esig <= BDFE_ESIG_LATCHED;
         endcase
      end
   end
   assign track_mode = (esig == BDFE_ESIG_TRACK);
   assign cs_pull_down = track_mode;

   // operating mode: undervoltage on either supply forces standby
   assign next_normal = in_s[`BDFE_IN_STBY_N] && !core_uv_flag && !io_uv_flag;
   assign normal_entry = next_normal && !normal_mode;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         normal_mode <= 1'b0;
      end else begin
         normal_mode <= next_normal;
      end
   end

   // remote wakeup flag; a wakeup on the very edge of normal entry wins over the clear
   assign next_wake_rise = !wake_flag && !normal_mode && in_s[`BDFE_IN_WAKE] && !core_uv_flag;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_flag <= 1'b0;
      end else if (next_wake_rise) begin
         wake_flag <= 1'b1;
      end else if (normal_entry) begin
         wake_flag <= 1'b0;
      end
   end

   // power-on flag: reset stands for power-up of the control logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_on_flag <= 1'b1;
      end else if (normal_entry) begin
         power_on_flag <= 1'b0;
      end
   end

   // thermal shutdown
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         thermal_flag <= 1'b0;
      end else if (!next_normal) begin
         thermal_flag <= 1'b0;
      end else if (in_s[`BDFE_IN_OTEMP]) begin
         thermal_flag <= 1'b1;
      end else if (in_s[`BDFE_IN_TEN_N]) begin
         thermal_flag <= 1'b0;
      end
   end

   // transmit-active watchdog; counts only while enable is low in normal mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_active_cnt <= '0;
         timeout_flag <= 1'b0;
      end else if (!next_normal || in_s[`BDFE_IN_TEN_N]) begin
         tx_active_cnt <= '0;
         timeout_flag <= 1'b0;
      end else if (tx_active_cnt == CW'(TX_ACTIVE_MAX_CYC - 1)) begin
         timeout_flag <= 1'b1;
      end else begin
         tx_active_cnt <= tx_active_cnt + 1'b1;
      end
   end

   // transmitter ready; the bus error flag is deliberately absent here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= next_normal && !timeout_flag && in_s[`BDFE_IN_GUARD] && !thermal_flag;
      end
   end
   // timeout and thermal block at once, without waiting a cycle for the ready register
   assign tx_on = tx_ready && !timeout_flag && !thermal_flag && !in_s[`BDFE_IN_TEN_N];
   assign tx_drive_enable = tx_on;

   // bus error: sample the bus a loop delay after each transmit-data edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         samp_cnt <= 4'h0;
      end else if (in_s[`BDFE_IN_TXD] != in_d[`BDFE_IN_TXD]) begin
         samp_cnt <= 4'(BUS_SAMPLE_CYC);
      end else if (samp_cnt != 4'h0) begin
         samp_cnt <= samp_cnt - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_err_flag <= 1'b0;
      end else if (!next_normal || in_s[`BDFE_IN_TEN_N]) begin
         bus_err_flag <= 1'b0;
      end else if (samp_cnt == 4'h1 && tx_on) begin
         bus_err_flag <= (in_s[`BDFE_IN_BUS_RX] != in_s[`BDFE_IN_TXD]);
      end
   end

   // serial frame checking, only in latched mode with the I/O supply good
   assign cs_fall = !in_s[`BDFE_IN_CS_N] && in_d[`BDFE_IN_CS_N];
   assign cs_rise = in_s[`BDFE_IN_CS_N] && !in_d[`BDFE_IN_CS_N];
   assign sck_fall = !in_s[`BDFE_IN_SCK] && in_d[`BDFE_IN_SCK] && !in_s[`BDFE_IN_CS_N];
   logic frame_viol;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         edge_cnt <= 6'h00;
         frame_viol <= 1'b0;
      end else if (cs_fall) begin
         edge_cnt <= 6'h00;
         frame_viol <= in_s[`BDFE_IN_SCK];
      end else if (sck_fall && edge_cnt != 6'h3f) begin
         edge_cnt <= edge_cnt + 1'b1;
      end
   end
   assign frame_bad = frame_viol || in_s[`BDFE_IN_SCK] || edge_cnt != `BDFE_SPI_FRAME_EDGES;
   assign readout_ok = cs_rise && !track_mode && !io_uv_flag && !frame_bad;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         spi_err_flag <= 1'b0;
      end else if (!track_mode && !io_uv_flag && ((cs_rise && frame_bad) || (cs_fall && in_s[`BDFE_IN_SCK]))) begin
         spi_err_flag <= 1'b1;
      end else if (cs_fall || mode_held) begin
         spi_err_flag <= 1'b0;
      end
   end

   // latched status bits: a set flag wins over the read-out reset
   assign flag_vec = {spi_err_flag, io_uv_flag, core_uv_flag, timeout_flag, thermal_flag, bus_err_flag,
                      power_on_flag};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_bits <= '0;
      end else begin
         status_bits <= flag_vec | (readout_ok ? '0 : status_bits);
      end
   end

   // common error flag
   assign any_err = |flag_vec[`BDFE_ST_SPI_ERR:`BDFE_ST_BUS_ERR];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         error_flag <= 1'b0;
      end else if (any_err) begin
         error_flag <= 1'b1;
      end else if (track_mode) begin
         error_flag <= 1'b0;
      end else begin
         error_flag <= |status_bits[`BDFE_ST_SPI_ERR:`BDFE_ST_BUS_ERR];
      end
   end

   // fault pin; in track mode a short indication is stretched to the minimum time
   assign ind_req = in_s[`BDFE_IN_STBY_N] ? error_flag : wake_flag;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt <= '0;
      end else if (ind_req) begin
         hold_cnt <= CW'(MIN_FAULT_IND_CYC);
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_indicator_n <= 1'b1;
      end else begin
         fault_indicator_n <= !(ind_req || (track_mode && hold_cnt > CW'(1)));
      end
   end

   // receive data: bus level in normal mode, wake indication otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         receive_data_out <= 1'b1;
      end else if (wake_flag && !in_s[`BDFE_IN_STBY_N]) begin
         receive_data_out <= 1'b0;
      end else begin
         receive_data_out <= normal_mode ? in_s[`BDFE_IN_BUS_RX] : 1'b1;
      end
   end

   a_wake_cleared: assert property (@(posedge clk) disable iff (!rstn)
      ($rose(normal_mode) && !$past(next_wake_rise)) |-> !wake_flag)
      else $error("wake flag survived normal entry");
   a_rxd_wake_low: assert property (@(posedge clk) disable iff (!rstn)
      (wake_flag && !in_s[`BDFE_IN_STBY_N]) |=> !receive_data_out && !fault_indicator_n)
      else $error("wake not shown on receive data and fault pin");
   a_ready_needs_normal: assert property (@(posedge clk) disable iff (!rstn)
      tx_ready |-> $past(next_normal) && !$past(thermal_flag) && !$past(timeout_flag))
      else $error("transmitter ready outside its terms");
   a_flags_leave_normal: assert property (@(posedge clk) disable iff (!rstn)
      !normal_mode |-> !thermal_flag && !timeout_flag && !bus_err_flag)
      else $error("normal-only flag kept outside normal");
   a_timeout_moment: assert property (@(posedge clk) disable iff (!rstn)
      $rose(timeout_flag) |-> $past(tx_active_cnt) == CW'(TX_ACTIVE_MAX_CYC - 1) && !tx_drive_enable)
      else $error("timeout set at the wrong count");
   a_error_follows: assert property (@(posedge clk) disable iff (!rstn) any_err |=> error_flag)
      else $error("error flag missed a contributing flag");
   a_track_error_clear: assert property (@(posedge clk) disable iff (!rstn)
      (track_mode && !any_err)[*2] |-> !error_flag)
      else $error("track mode error flag not cleared");
   a_track_hold: assert property (@(posedge clk) disable iff (!rstn)
      (track_mode && $rose(fault_indicator_n)) |-> $past(hold_cnt) <= CW'(1) && !$past(ind_req))
      else $error("fault indication released early");
   a_frame_error: assert property (@(posedge clk) disable iff (!rstn)
      (cs_rise && frame_bad && !track_mode && !io_uv_flag) |=> spi_err_flag ##1 status_bits[`BDFE_ST_SPI_ERR])
      else $error("bad frame not flagged");
   a_track_sticky: assert property (@(posedge clk) disable iff (!rstn)
      track_mode |=> track_mode && cs_pull_down)
      else $error("track mode lost");
endmodule // bdfe_top

/* verif/bdfe_host_model.sv */
// host side model: serial read-out frames and the error-mode request on the chip-select pins
`timescale 1ns/100ps
module bdfe_host_model (
   input wire logic clk,
   output logic spi_cs_n,
   output logic spi_sck
);
   // idle: deselected with the clock low, so any frame starts clean
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
   end

   // every change lands a fixed 1 ns after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // each clock level lasts 4 cycles so the two-stage synchroniser sees every edge
   task automatic frame(input int edges);
      step(1);
      spi_cs_n = 1'b0;
      step(4);
      for (int i = 0; i < edges; i++) begin
         spi_sck = 1'b1;
         step(4);
         spi_sck = 1'b0;
         step(4);
      end
      spi_cs_n = 1'b1;
      step(8);
   endtask

   // clock high before select goes low, then both are left there like tied pins
   task automatic track_request(input int cycles);
      spi_sck = 1'b1;
      step(2);
      spi_cs_n = 1'b0;
      step(cycles);
   endtask
endmodule // bdfe_host_model

/* verif/bdfe_top_tb.sv */
// self-checking bench of the bus-driver flag and error logic
`timescale 1ns/100ps
module bdfe_top_tb;
   typedef struct {int sel; logic val;} bdfe_note_type;
   localparam int RXD = 0, FLT = 1, TXE = 2, RDY = 3, NRM = 4, WAKE = 5, PWR = 6, BUS = 7, THR = 8;
   localparam int TMO = 9, CUV = 10, IUV = 11, SPI = 12, ERR = 13, TRK = 14, PUL = 15, ST = 16;
   logic clk = 1'b0;
   logic rstn;
   logic tx_data_in, transmit_enable_n, guardian_enable, standby_n, bus_rx_level, bus_wakeup;
   logic over_temp, core_below_uv, io_below_uv;
   wire logic spi_cs_n, spi_sck;
   logic receive_data_out, fault_indicator_n, tx_drive_enable, tx_ready, normal_mode, wake_flag;
   logic power_on_flag, bus_err_flag, thermal_flag, timeout_flag, core_uv_flag, io_uv_flag;
   logic spi_err_flag, error_flag, track_mode, cs_pull_down;
   logic [6:0] status_bits;
   logic [22:0] obs;
   bdfe_note_type notes[$];
   bdfe_note_type note;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed = 63061;

   always #5 clk = ~clk;

   // short counts keep the run brief; the filter, timeout and hold waits below are sized for them
   bdfe_top #(.TX_ACTIVE_MAX_CYC(50), .CORE_UV_DETECT_CYC(5), .CORE_UV_RECOVERY_CYC(8), .IO_UV_DETECT_CYC(5),
      .IO_UV_RECOVERY_CYC(8), .MODE_SELECT_CYC(10), .MIN_FAULT_IND_CYC(12), .BUS_SAMPLE_CYC(4)) dut (
      .clk(clk), .rstn(rstn), .tx_data_in(tx_data_in), .transmit_enable_n(transmit_enable_n),
      .guardian_enable(guardian_enable), .standby_n(standby_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .bus_rx_level(bus_rx_level), .bus_wakeup(bus_wakeup), .over_temp(over_temp),
      .core_below_uv(core_below_uv), .io_below_uv(io_below_uv), .receive_data_out(receive_data_out),
      .fault_indicator_n(fault_indicator_n), .tx_drive_enable(tx_drive_enable), .tx_ready(tx_ready),
      .normal_mode(normal_mode), .wake_flag(wake_flag), .power_on_flag(power_on_flag),
      .bus_err_flag(bus_err_flag), .thermal_flag(thermal_flag), .timeout_flag(timeout_flag),
      .core_uv_flag(core_uv_flag), .io_uv_flag(io_uv_flag), .spi_err_flag(spi_err_flag),
      .error_flag(error_flag), .status_bits(status_bits), .track_mode(track_mode), .cs_pull_down(cs_pull_down));

   bdfe_host_model host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck));

   // all watched outputs in one vector, indexed by the constants above
   assign obs = {status_bits, cs_pull_down, track_mode, error_flag, spi_err_flag, io_uv_flag, core_uv_flag,
      timeout_flag, thermal_flag, bus_err_flag, power_on_flag, wake_flag, normal_mode, tx_ready,
      tx_drive_enable, fault_indicator_n, receive_data_out};

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input int sel, input logic val);
      notes.push_back('{sel, val});
   endtask

   task automatic chk_st(input logic [6:0] e);
      for (int i = 0; i < 7; i++) chk(ST + i, e[i]);
   endtask

   // toggles transmit data twice, bus echo matching or not; random hold keeps it under the timeout
   task automatic tx_phase(input logic mm);
      transmit_enable_n = 1'b0;
      for (int i = 0; i < 2; i++) begin
         tx_data_in = ~tx_data_in;
         bus_rx_level = tx_data_in ^ mm;
         cyc(8 + ($random(seed) & 3));
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // notes are compared on the falling edge, once the outputs have settled
   always @(negedge clk) begin
      while (notes.size() > 0) begin
         note = notes.pop_front();
         samples_checked++;
         if (obs[note.sel] !== note.val) begin
            mismatches++;
            $display("ERROR %0t output %0d is %b, expected %b", $time, note.sel, obs[note.sel], note.val);
         end
      end
   end

   // cycle ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end

   // start values: enable released, recessive bus, supplies good, standby commanded
   initial begin
      rstn = 1'b0;
      {tx_data_in, guardian_enable, standby_n, bus_wakeup, over_temp, core_below_uv, io_below_uv} = 7'h00;
      transmit_enable_n = 1'b1;
      bus_rx_level = 1'b1;
      repeat (6) @(posedge clk);
      #1 rstn = 1'b1;
      cyc(1);
      chk(PWR, 1'b1);
      chk(TRK, 1'b0);
      chk(ERR, 1'b0);
      chk(FLT, 1'b1);
      io_below_uv = 1'b1;
      cyc(12);
      chk(IUV, 1'b1);
      chk(ERR, 1'b1);
      bus_wakeup = 1'b1;
      cyc(3);
      bus_wakeup = 1'b0;
      io_below_uv = 1'b0;
      cyc(6);
      chk(WAKE, 1'b1);
      chk(IUV, 1'b0);
      chk(RXD, 1'b0);
      chk(FLT, 1'b0);
      standby_n = 1'b1;
      guardian_enable = 1'b1;
      cyc(6);
      chk(NRM, 1'b1);
      chk(WAKE, 1'b0);
      chk(PWR, 1'b0);
      chk(RDY, 1'b1);
      chk(ERR, 1'b1);
      chk(FLT, 1'b0);
      guardian_enable = 1'b0;
      cyc(5);
      chk(RDY, 1'b0);
      guardian_enable = 1'b1;
      tx_phase(1'b1);
      chk(BUS, 1'b1);
      chk(TXE, 1'b1);
      tx_phase(1'b0);
      chk(BUS, 1'b0);
      transmit_enable_n = 1'b1;
      cyc(5);
      transmit_enable_n = 1'b0;
      cyc(60);
      chk(TMO, 1'b1);
      chk(TXE, 1'b0);
      chk(RDY, 1'b0);
      transmit_enable_n = 1'b1;
      cyc(5);
      chk(TMO, 1'b0);
      chk(RDY, 1'b1);
      over_temp = 1'b1;
      cyc(5);
      chk(THR, 1'b1);
      chk(RDY, 1'b0);
      over_temp = 1'b0;
      cyc(5);
      chk(THR, 1'b0);
      core_below_uv = 1'b1;
      cyc(12);
      chk(CUV, 1'b1);
      chk(NRM, 1'b0);
      core_below_uv = 1'b0;
      cyc(16);
      chk(CUV, 1'b0);
      chk_st(7'h3F);
      host.frame(15);
      chk(SPI, 1'b1);
      chk_st(7'h7F);
      host.frame(16);
      chk(SPI, 1'b0);
      chk_st(7'h00);
      chk(ERR, 1'b0);
      chk(FLT, 1'b1);
      host.track_request(20);
      chk(TRK, 1'b1);
      chk(PUL, 1'b1);
      over_temp = 1'b1;
      cyc(5);
      over_temp = 1'b0;
      cyc(8);
      chk(ERR, 1'b0);
      chk(FLT, 1'b0);
      cyc(14);
      chk(FLT, 1'b1);
      cyc(2);
      end_sim();
   end
endmodule // bdfe_top_tb
